// >>> design/awt_defines.svh
`ifndef AWT_DEFINES_SVH
`define AWT_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AWT_OFS_CTRL_STAT    2'h0
`define AWT_OFS_PRESC_SEL    2'h1
`define AWT_OFS_TBASE_SEL    2'h2

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define AWT_BIT_FLAG         5
`define AWT_BIT_ENABLE       4
`define AWT_BIT_MEASURE      0
`define AWT_PRESC_RESET      6'h3f
`define AWT_TBASE_RESET      4'h0
`define AWT_TBASE_OFF        4'h0
`define AWT_TBASE_X5         4'he
`define AWT_TBASE_X30        4'hf
`define AWT_RDATA_NONE       8'h00

// ----------------------------------------
// Interval lengths in prescaler ticks
// ----------------------------------------
`define AWT_LEN_X5           16'h2800
`define AWT_LEN_X30          16'hf000
`define AWT_LEN_ONE          16'h0001

// ----------------------------------------
// Crystal path divider, in crystal edges
// ----------------------------------------
`define AWT_XTAL_DIV_LAST    4'hf

`endif

// >>> design/awt_pkg.sv
package awt_pkg;

   typedef enum logic {
      awt_src_rc,
      awt_src_xtal
   } awt_src_e;

   typedef enum logic {
      awt_tmr_idle,
      awt_tmr_run
   } awt_tmr_state_e;

   typedef enum logic [1:0] {
      awt_core_run,
      awt_core_halt,
      awt_core_wait
   } awt_core_state_e;

endpackage

// >>> design/awt_if.sv
`timescale 1ns/1ps
interface awt_if;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       halt_active;
   logic       wait_active;
   logic       wakeup;
   logic       ls_capture;

   modport dev (
      input  reg_addr,
      input  reg_wdata,
      input  reg_wr,
      input  reg_rd,
      output reg_rdata,
      input  halt_active,
      input  wait_active,
      output wakeup,
      output ls_capture
   );

   modport core (
      output reg_addr,
      output reg_wdata,
      output reg_wr,
      output reg_rd,
      input  reg_rdata,
      output halt_active,
      output wait_active,
      input  wakeup,
      input  ls_capture
   );
endinterface

// >>> design/awt_device.sv
`timescale 1ns/1ps
`include "awt_defines.svh"
module awt_device (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              low_speed_rc_osc,
   input  wire logic              ext_crystal_osc,
   input  wire awt_pkg::awt_src_e ls_src_sel,
   awt_if.dev                     bus
);
   import awt_pkg::*;

   // ----------------------------------------
   // Interval decode
   // ----------------------------------------
   function automatic logic [15:0] interval_len(input logic [3:0] tb);
      logic [15:0] len;
      len = 16'h0000;
      case (tb)
         `AWT_TBASE_OFF: len = 16'h0000;
         `AWT_TBASE_X5:  len = `AWT_LEN_X5;
         `AWT_TBASE_X30: len = `AWT_LEN_X30;
         default:        len = `AWT_LEN_ONE << (tb - 4'h1);
      endcase
      return len;
   endfunction

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic           rc_s1;
   logic           rc_s2;
   logic           rc_s3;
   logic           xt_s1;
   logic           xt_s2;
   logic           xt_s3;
   logic [3:0]     xt_div_cnt;
   logic           xt_div_lvl;
   logic           xt_tick;
   logic           ls_tick;
   logic           ls_level;
   logic           wakeup_flag;
   logic           wakeup_enable;
   logic           lsclk_measure_connect;
   logic [5:0]     async_prescale_sel;
   logic [3:0]     timebase_sel;
   logic           lp;
   logic           lp_d;
   logic           lp_entry;
   awt_tmr_state_e tmr_state;
   logic [5:0]     presc_cnt;
   logic [15:0]    rank_cnt;
   logic           presc_on;
   logic           pre_tick;
   logic           expire;
   logic           flag_read;

   // ----------------------------------------
   // Low-speed clock source
   // ----------------------------------------
   // Both oscillators are foreign to clk_sys; two flops before any use
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
         xt_s1 <= 1'b0;
         xt_s2 <= 1'b0;
         xt_s3 <= 1'b0;
      end else begin
         rc_s1 <= low_speed_rc_osc;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
         xt_s1 <= ext_crystal_osc;
         xt_s2 <= xt_s1;
         xt_s3 <= xt_s2;
      end
   end

   // Crystal path divided down; clk_sys must run well above crystal rate
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         xt_div_cnt <= 4'h0;
         xt_div_lvl <= 1'b0;
      end else if (xt_s2 && !xt_s3) begin
         if (xt_div_cnt == `AWT_XTAL_DIV_LAST) begin
            xt_div_cnt <= 4'h0;
            xt_div_lvl <= ~xt_div_lvl;
         end else begin
            xt_div_cnt <= xt_div_cnt + 4'h1;
         end
      end
   end

   assign xt_tick  = xt_s2 && !xt_s3 && (xt_div_cnt == `AWT_XTAL_DIV_LAST) && xt_div_lvl;
   assign ls_tick  = (ls_src_sel == awt_src_rc) ? (rc_s2 && !rc_s3) : xt_tick;
   assign ls_level = (ls_src_sel == awt_src_rc) ? rc_s2 : xt_div_lvl;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wakeup_enable         <= 1'b0;
         lsclk_measure_connect <= 1'b0;
         async_prescale_sel    <= `AWT_PRESC_RESET;
         timebase_sel          <= `AWT_TBASE_RESET;
      end else if (bus.reg_wr) begin
         case (bus.reg_addr)
            `AWT_OFS_CTRL_STAT: begin
               wakeup_enable         <= bus.reg_wdata[`AWT_BIT_ENABLE];
               lsclk_measure_connect <= bus.reg_wdata[`AWT_BIT_MEASURE];
            end
            `AWT_OFS_PRESC_SEL: async_prescale_sel <= bus.reg_wdata[5:0];
            `AWT_OFS_TBASE_SEL: timebase_sel <= bus.reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   assign flag_read = bus.reg_rd && (bus.reg_addr == `AWT_OFS_CTRL_STAT);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus.reg_rdata <= `AWT_RDATA_NONE;
      end else if (bus.reg_rd) begin
         case (bus.reg_addr)
            `AWT_OFS_CTRL_STAT: bus.reg_rdata <= {2'b00, wakeup_flag, wakeup_enable,
                                                  3'b000, lsclk_measure_connect};
            `AWT_OFS_PRESC_SEL: bus.reg_rdata <= {2'b00, async_prescale_sel};
            `AWT_OFS_TBASE_SEL: bus.reg_rdata <= {4'h0, timebase_sel};
            default:            bus.reg_rdata <= `AWT_RDATA_NONE;
         endcase
      end
   end

   // Set beats the read-clear so a wakeup in the read cycle is kept
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wakeup_flag <= 1'b0;
      end else if (expire) begin
         wakeup_flag <= 1'b1;
      end else if (flag_read) begin
         wakeup_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Low-power entry
   // ----------------------------------------
   assign lp       = bus.halt_active || bus.wait_active;
   assign lp_entry = lp && !lp_d;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lp_d <= 1'b0;
      end else begin
         lp_d <= lp;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tmr_state <= awt_tmr_idle;
      end else begin
         case (tmr_state)
            awt_tmr_idle: begin
               if (lp_entry && wakeup_enable && timebase_sel != `AWT_TBASE_OFF) begin
                  tmr_state <= awt_tmr_run;
               end
            end
            awt_tmr_run: begin
               if (!lp || !wakeup_enable || timebase_sel == `AWT_TBASE_OFF) begin
                  tmr_state <= awt_tmr_idle;
               end
            end
            default: tmr_state <= awt_tmr_idle;
         endcase
      end
   end

   // ----------------------------------------
   // Prescaler and rank counter
   // ----------------------------------------
   assign presc_on = (tmr_state == awt_tmr_run)
                     && (async_prescale_sel != `AWT_PRESC_RESET);
   // Factor is field plus two, so terminal count is field plus one
   assign pre_tick = presc_on && ls_tick
                     && (presc_cnt == async_prescale_sel + 6'h01);
   assign expire   = pre_tick && (rank_cnt == interval_len(timebase_sel) - 16'h0001);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         presc_cnt <= 6'h00;
      end else if (lp_entry || !presc_on || pre_tick) begin
         presc_cnt <= 6'h00;
      end else if (ls_tick) begin
         presc_cnt <= presc_cnt + 6'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rank_cnt <= 16'h0000;
      end else if (lp_entry || tmr_state != awt_tmr_run || expire) begin
         rank_cnt <= 16'h0000;
      end else if (pre_tick) begin
         rank_cnt <= rank_cnt + 16'h0001;
      end
   end

   // ----------------------------------------
   // Outputs to the core
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus.wakeup     <= 1'b0;
         bus.ls_capture <= 1'b0;
      end else begin
         bus.wakeup     <= expire;
         bus.ls_capture <= lsclk_measure_connect && ls_level;
      end
   end

endmodule

// >>> design/awt_core.sv
`timescale 1ns/1ps
`include "awt_defines.svh"
module awt_core (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              user_wr,
   input  wire logic              user_rd,
   input  wire logic [1:0]        user_addr,
   input  wire logic [7:0]        user_wdata,
   input  wire logic              user_halt,
   input  wire logic              user_wait,
   input  wire logic              user_ext_wake,
   output      logic [7:0]        user_rdata,
   output      logic              user_rdata_valid,
   output      logic              user_woken,
   output      awt_pkg::awt_core_state_e user_state,
   awt_if.core                    bus
);
   import awt_pkg::*;

   logic rd_d1;

   // ----------------------------------------
   // Register access, only while running
   // ----------------------------------------
   // A halted or waiting core issues no accesses; such requests drop
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus.reg_addr  <= `AWT_OFS_CTRL_STAT;
         bus.reg_wdata <= `AWT_RDATA_NONE;
         bus.reg_wr    <= 1'b0;
         bus.reg_rd    <= 1'b0;
      end else begin
         bus.reg_addr  <= user_addr;
         bus.reg_wdata <= user_wdata;
         bus.reg_wr    <= user_wr && (user_state == awt_core_run);
         bus.reg_rd    <= user_rd && !user_wr && (user_state == awt_core_run);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_d1            <= 1'b0;
         user_rdata       <= `AWT_RDATA_NONE;
         user_rdata_valid <= 1'b0;
      end else begin
         rd_d1            <= bus.reg_rd;
         user_rdata_valid <= rd_d1;
         if (rd_d1) begin
            user_rdata <= bus.reg_rdata;
         end
      end
   end

   // ----------------------------------------
   // Low-power state
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         user_state      <= awt_core_run;
         user_woken      <= 1'b0;
         bus.halt_active <= 1'b0;
         bus.wait_active <= 1'b0;
      end else begin
         user_woken <= 1'b0;
         case (user_state)
            awt_core_run: begin
               if (user_halt) begin
                  user_state      <= awt_core_halt;
                  bus.halt_active <= 1'b1;
               end else if (user_wait) begin
                  user_state      <= awt_core_wait;
                  bus.wait_active <= 1'b1;
               end
            end
            awt_core_halt, awt_core_wait: begin
               if (bus.wakeup || user_ext_wake) begin
                  user_state      <= awt_core_run;
                  user_woken      <= 1'b1;
                  bus.halt_active <= 1'b0;
                  bus.wait_active <= 1'b0;
               end
            end
            default: begin
               user_state      <= awt_core_run;
               bus.halt_active <= 1'b0;
               bus.wait_active <= 1'b0;
            end
         endcase
      end
   end

endmodule

// >>> test/awt_props.sv
`timescale 1ns/1ps
module awt_props (
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       halt_active,
   input wire logic       wait_active,
   input wire logic       wakeup,
   input wire logic       ls_capture
);
   logic       sh_en;
   logic [5:0] sh_apr;
   logic [3:0] sh_tb;

   // ------
   // Shadow of setup as seen on the wire, so the checks need no peek inside
   // ------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sh_en  <= 1'b0;
         sh_apr <= 6'h3f;
         sh_tb  <= 4'h0;
      end else if (reg_wr) begin
         if (reg_addr == 2'h0) sh_en <= reg_wdata[4];
         if (reg_addr == 2'h1) sh_apr <= reg_wdata[5:0];
         if (reg_addr == 2'h2) sh_tb <= reg_wdata[3:0];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_rd_ctrl;
      reg_rd && reg_addr == 2'h0 && !wakeup;
   endsequence

   chk_wake_in_lp: assert property (wakeup |-> halt_active || wait_active)
      else $error("wakeup outside low power");
   chk_wake_pulse: assert property (wakeup |=> !wakeup)
      else $error("wakeup longer than one cycle");
   chk_wake_enabled: assert property (wakeup |-> sh_en && sh_tb != 4'h0)
      else $error("wakeup while disabled");
   chk_wake_presc: assert property (wakeup |-> sh_apr != 6'h3f)
      else $error("wakeup with prescaler at reset value");
   chk_ctrl_rsvd: assert property (reg_rd && reg_addr == 2'h0
      |=> (reg_rdata & 8'hce) == 8'h00)
      else $error("control reserved bits not zero");
   chk_presc_read: assert property (reg_rd && reg_addr == 2'h1
      |=> reg_rdata == {2'h0, $past(sh_apr)})
      else $error("prescaler readback wrong");
   chk_tbase_read: assert property (reg_rd && reg_addr == 2'h2
      |=> reg_rdata == {4'h0, $past(sh_tb)})
      else $error("timebase readback wrong");
   chk_unmapped_zero: assert property (reg_rd && reg_addr == 2'h3
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_flag_clear: assert property (s_rd_ctrl ##1 s_rd_ctrl |=> !reg_rdata[5])
      else $error("flag survived a status read");
   chk_meas_off: assert property (reg_wr && reg_addr == 2'h0 && !reg_wdata[0]
      |-> ##3 (!ls_capture)[*4])
      else $error("capture path still connected");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
   import awt_pkg::*;
   logic            clk_sys;
   logic            rst_b;
   logic            rc_osc;
   logic            xt_osc;
   awt_src_e        ls_sel;
   logic            user_wr;
   logic            user_rd;
   logic [1:0]      user_addr;
   logic [7:0]      user_wdata;
   logic            user_halt;
   logic            user_wait;
   logic            user_ext_wake;
   logic [7:0]      user_rdata;
   logic            user_rdata_valid;
   logic            user_woken;
   awt_core_state_e user_state;
   int              err_count;
   int              compares;

   awt_if bus_if ();
   awt_device u_awt_device (.clk_sys, .rst_b, .low_speed_rc_osc(rc_osc),
      .ext_crystal_osc(xt_osc), .ls_src_sel(ls_sel), .bus(bus_if));
   awt_core u_awt_core (.clk_sys, .rst_b, .user_wr, .user_rd, .user_addr, .user_wdata,
      .user_halt, .user_wait, .user_ext_wake, .user_rdata, .user_rdata_valid,
      .user_woken, .user_state, .bus(bus_if));
   awt_props u_awt_props (.clk_sys, .rst_b, .reg_addr(bus_if.reg_addr),
      .reg_wdata(bus_if.reg_wdata), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
      .reg_rdata(bus_if.reg_rdata), .halt_active(bus_if.halt_active),
      .wait_active(bus_if.wait_active), .wakeup(bus_if.wakeup),
      .ls_capture(bus_if.ls_capture));

   always #50 clk_sys = ~clk_sys;
   always #500 rc_osc = ~rc_osc;
   // Crystal at a quarter of clk_sys, the fastest the sync path allows
   always #200 xt_osc = ~xt_osc;

   // ------
   // Shared tasks
   // ------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         err_count++;
         $display("BAD %s exp %0h got %0h", nm, ex, got);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      user_addr = a;
      user_wdata = d;
      user_wr = 1'b1;
      @(negedge clk_sys);
      user_wr = 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] ex, input string nm);
      int n;
      @(negedge clk_sys);
      user_addr = a;
      user_rd = 1'b1;
      @(negedge clk_sys);
      user_rd = 1'b0;
      n = 0;
      while (user_rdata_valid !== 1'b1 && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      // Valid stands two negedges after the one that dropped the request
      chk("rd_latency", 2, n);
      chk(nm, ex, user_rdata);
   endtask

   // Counts cycles until woken; lim bounds the wait
   task automatic slp(input logic wt, input int lim, output int cyc);
      @(negedge clk_sys);
      user_halt = !wt;
      user_wait = wt;
      @(negedge clk_sys);
      user_halt = 1'b0;
      user_wait = 1'b0;
      chk("core_state", wt ? awt_core_wait : awt_core_halt, user_state);
      cyc = 1;
      while (user_woken !== 1'b1 && cyc < lim) begin
         @(negedge clk_sys);
         cyc++;
      end
   endtask

   task automatic cnt_cap(output int n);
      n = 0;
      repeat (40) begin
         @(negedge clk_sys);
         n += int'(bus_if.ls_capture === 1'b1);
      end
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_regs;
      int n;
      rd(2'h0, 8'h00, "ctrl_rst");
      rd(2'h1, 8'h3f, "presc_rst");
      rd(2'h2, 8'h00, "tbase_rst");
      rd(2'h3, 8'h00, "unmapped_rst");
      for (int i = 0; i < 4; i++) wr(i[1:0], 8'hff);
      rd(2'h0, 8'h11, "ctrl_ro");
      rd(2'h1, 8'h3f, "presc_ro");
      rd(2'h2, 8'h0f, "tbase_ro");
      rd(2'h3, 8'h00, "unmapped_wr");
      cnt_cap(n);
      chk("meas_on", 1, n > 10 && n < 30);
      wr(2'h0, 8'h10);
      repeat (4) @(negedge clk_sys);
      cnt_cap(n);
      chk("meas_off", 0, n);
   endtask

   task automatic t_nowake;
      logic [7:0] cfg [3][3] = '{'{8'h3f, 8'h01, 8'h10}, '{8'h00, 8'h00, 8'h10},
                                 '{8'h00, 8'h01, 8'h00}};
      int         m;
      for (int i = 0; i < 3; i++) begin
         wr(2'h1, cfg[i][0]);
         wr(2'h2, cfg[i][1]);
         wr(2'h0, cfg[i][2]);
         slp(1'b0, 800, m);
         chk("no_wake", 800, m);
         @(negedge clk_sys);
         user_ext_wake = 1'b1;
         @(negedge clk_sys);
         user_ext_wake = 1'b0;
         repeat (3) @(negedge clk_sys);
         rd(2'h0, cfg[i][2], "ctrl_noflag");
      end
   endtask

   task automatic t_timing;
      // Factors kept inside each code's span
      logic [5:0] apr [5] = '{6'h00, 6'h1e, 6'h1e, 6'h3e, 6'h3e};
      logic [3:0] tbc [5] = '{4'h1, 4'h4, 4'h2, 4'h1, 4'h3};
      int         e;
      int         m;
      for (int i = 0; i < 5; i++) begin
         wr(2'h1, {2'h0, apr[i]});
         wr(2'h2, {4'h0, tbc[i]});
         wr(2'h0, 8'h10);
         e = (apr[i] + 2) * (1 << (tbc[i] - 1)) * 10;
         // Start just after a low-speed edge so the phase is known
         @(posedge rc_osc);
         repeat (4) @(negedge clk_sys);
         slp(i[0], e + 40, m);
         chk("interval", 1, m >= e - 6 && m <= e + 5);
         rd(2'h0, 8'h30, "ctrl_flag");
         @(negedge clk_sys);
         user_addr = 2'h0;
         user_rd = 1'b1;
         repeat (2) @(negedge clk_sys);
         user_rd = 1'b0;
         repeat (4) @(negedge clk_sys);
         chk("ctrl_b2b", 8'h10, user_rdata);
      end
   endtask

   // Divider runs free, so the first tick lands anywhere in one tick period
   task automatic t_xtal;
      int m;
      @(negedge clk_sys);
      ls_sel = awt_src_xtal;
      wr(2'h1, 8'h00);
      wr(2'h2, 8'h01);
      wr(2'h0, 8'h10);
      slp(1'b0, 300, m);
      chk("xtal_interval", 1, m >= 128 && m <= 262);
      rd(2'h0, 8'h30, "xtal_flag");
   endtask

   task automatic close_out;
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #3_000_000;
      err_count++;
      close_out;
   end

   initial begin
      clk_sys = 1'b0;
      rc_osc = 1'b0;
      xt_osc = 1'b0;
      ls_sel = awt_src_rc;
      rst_b = 1'b0;
      user_wr = 1'b0;
      user_rd = 1'b0;
      user_addr = 2'h0;
      user_wdata = 8'h00;
      user_halt = 1'b0;
      user_wait = 1'b0;
      user_ext_wake = 1'b0;
      err_count = 0;
      compares = 0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      t_regs;
      t_nowake;
      t_timing;
      t_xtal;
      close_out;
   end
endmodule
